// file: pkg/nvmsec_pkg.sv
// Purpose: shared constants and carrier types for the nvm security and command decoder
// Assumes: 32-bit classic wishbone register access, one system clock
// Notes:   offsets are byte addresses of aligned words
package nvmsec_pkg;

    // ********************************
    // register offsets
    // ********************************
    localparam logic [7:0] OFS_CMD  = 8'h00; // command_code launch
    localparam logic [7:0] OFS_STAT = 8'h04; // status flags, write one to clear except busy and lock
    localparam logic [7:0] OFS_KEYA = 8'h08; // presented key words 0 and 1
    localparam logic [7:0] OFS_KEYB = 8'h0c; // presented key words 2 and 3
    localparam logic [7:0] OFS_PROT = 8'h10; // protection open and disable bits
    localparam logic [7:0] OFS_SEC  = 8'h14; // security_status_register, read only
    localparam logic [7:0] OFS_DBG  = 8'h18; // debug_access_control

    // ********************************
    // field positions
    // ********************************
    localparam int CMD_EE_BIT      = 8;  // command targets the eeprom block
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_ACCESS_ERROR_FLAG_BIT = 1;
    localparam int STAT_PVIOL_BIT  = 2;
    localparam int STAT_LOCK_BIT   = 3;
    localparam int STAT_FAIL_BIT   = 4;
    localparam int PROT_FOPEN_BIT  = 0;
    localparam int PROT_HDIS_BIT   = 1;
    localparam int PROT_LDIS_BIT   = 2;
    localparam int PROT_EOPEN_BIT  = 3;
    localparam int DBG_ERASE_BIT   = 0;
    localparam int DBG_RST_BIT     = 3;

    // ********************************
    // encodings and reset values
    // ********************************
    localparam logic [1:0]  SEC_UNSECURED   = 2'h2;
    localparam logic [1:0]  KEY_ENABLE_FIELD_ENABLED   = 2'h2;
    localparam logic [7:0]  SEC_ERASED_BYTE = 8'hfe;
    localparam logic [7:0]  SEC_RESET_BYTE  = 8'hff; // secured until the byte is loaded
    localparam logic [15:0] KEY_ALL_ZERO    = 16'h0000;
    localparam logic [15:0] KEY_ALL_ONE     = 16'hffff;
    localparam logic [3:0]  KEY_CMP_CYCLES  = 4'h4; // read-blocked compare window

    // ********************************
    // command codes
    // ********************************
    localparam logic [7:0] CMD_EV_ALL    = 8'h01;
    localparam logic [7:0] CMD_EV_BLOCK  = 8'h02;
    localparam logic [7:0] CMD_EV_SECT   = 8'h03;
    localparam logic [7:0] CMD_RD_ONCE   = 8'h04;
    localparam logic [7:0] CMD_PGM       = 8'h06;
    localparam logic [7:0] CMD_PGM_ONCE  = 8'h07;
    localparam logic [7:0] CMD_ERS_ALL   = 8'h08;
    localparam logic [7:0] CMD_ERS_BLK   = 8'h09;
    localparam logic [7:0] CMD_ERS_SECT  = 8'h0a;
    localparam logic [7:0] CMD_UNSECURE  = 8'h0b;
    localparam logic [7:0] CMD_KEY_VER   = 8'h0c;
    localparam logic [7:0] CMD_MRG_USER  = 8'h0d;
    localparam logic [7:0] CMD_MRG_FACT  = 8'h0e;
    localparam logic [7:0] CMD_EV_EESECT = 8'h10;
    localparam logic [7:0] CMD_EE_PGM    = 8'h11;
    localparam logic [7:0] CMD_EE_ERSECT = 8'h12;

    // ********************************
    // types
    // ********************************
    typedef enum logic [2:0] {
        NVMSEC_IDLE  = 3'b000,
        NVMSEC_EXEC  = 3'b001,
        NVMSEC_KEY   = 3'b011,
        NVMSEC_DERS  = 3'b010,
        NVMSEC_DPROG = 3'b110
    } nvmsec_state_t;

    // request to the array engine
    typedef struct packed {
        logic       start;
        logic [7:0] code;
        logic       ee_sel;
    } nvmsec_op_t;

    // nonvolatile configuration as read from the array
    typedef struct packed {
        logic [63:0] keys;     // four stored key words, word 0 lowest
        logic [7:0]  sec_byte; // stored security byte
        logic        once_used;
    } nvmsec_cfg_t;

endpackage : nvmsec_pkg

// file: hw/nvmsec_top.sv
// Purpose: backdoor key check, debug mass erase and command decode of the nvm controller
// Assumes: array engine answers each started operation with one done pulse
// Notes:   all outputs but the constant sec_byte_val come from the single state register
// Summary of operation
// - compare against four stored 16-bit key words
// - key command needs key_enable_field enabled
// - key match sets security field to 10
// - stored keys 0000 or ffff never match
// - block array reads during key compare
// - failed compare locks key command until reset
// - key check leaves security byte, protection alone
// - key check never writes stored keys
// - erase bit during device reset starts mass erase
// - erase end: clear bit, hold cpu, unsecure
// - commands gated by mode and security
// - codes 01 02 03 are erase verifies
// - 04 reads once field, 07 programs once
// - 06 programs up to two longwords
// - 08 erase all needs all protection open
// - 09 flash block erase needs flash open
// - 0a erases one flash sector
// - 0b erases all then verifies, unsecures
// - 0c is backdoor key verification
// - 0d user, 0e factory margin level
// - 10 11 12 are the eeprom commands
// - security loaded at reset, new byte next reset
// - invalid code sets access_error_flag, not run
//
// The address map and register access over Wishbone were left to the implementer.
module nvmsec_top (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // device reset pin, asynchronous
    input  wire logic               sys_reset_n,
    input  wire logic               special_mode,
    // array engine
    input  wire nvmsec_pkg::nvmsec_cfg_t nvm_cfg,
    input  wire logic               op_done,
    input  wire logic               op_fail,
    output nvmsec_pkg::nvmsec_op_t  op_req,
    output logic                    sec_byte_wr,
    output logic      [7:0]         sec_byte_val,
    output logic                    read_block,
    output logic                    cpu_hold
);

    typedef struct packed {
        nvmsec_pkg::nvmsec_state_t state;
        logic                      ack;
        logic [31:0]               dat;
        logic [7:0]                cmd_code;
        logic                      cmd_ee;
        logic [63:0]               keys_in;
        logic                      fopen;
        logic                      hdis;
        logic                      ldis;
        logic                      eopen;
        logic [7:0]                sec;
        logic                      acc_err;
        logic                      prot_viol;
        logic                      op_failed;
        logic                      lockout;
        logic                      dbg_erase;
        logic                      dbg_rst;
        logic                      cpu_hold;
        logic                      read_block;
        nvmsec_pkg::nvmsec_op_t    op;
        logic                      sec_wr;
        logic [3:0]                cnt;
        logic                      rst_s1;
        logic                      rst_s2;
        logic                      held_d;
        logic                      loaded;
    } nvmsec_st_t;

    nvmsec_st_t st_r;
    nvmsec_st_t st_nxt;

    // ********************************
    // decode functions
    // ********************************
    // codes that name a command at all
    function automatic logic code_valid(input logic [7:0] c);
        unique case (c)
            nvmsec_pkg::CMD_EV_ALL, nvmsec_pkg::CMD_EV_BLOCK, nvmsec_pkg::CMD_EV_SECT,
            nvmsec_pkg::CMD_RD_ONCE, nvmsec_pkg::CMD_PGM_ONCE,
            nvmsec_pkg::CMD_PGM,
            nvmsec_pkg::CMD_ERS_ALL, nvmsec_pkg::CMD_ERS_BLK, nvmsec_pkg::CMD_ERS_SECT,
            nvmsec_pkg::CMD_UNSECURE, nvmsec_pkg::CMD_KEY_VER,
            nvmsec_pkg::CMD_MRG_USER, nvmsec_pkg::CMD_MRG_FACT,
            nvmsec_pkg::CMD_EV_EESECT, nvmsec_pkg::CMD_EE_PGM,
            nvmsec_pkg::CMD_EE_ERSECT: code_valid = 1'b1;
            default: code_valid = 1'b0;
        endcase
    endfunction

    // secured parts only run verify-all, unsecure, key check, and erase-all in special mode
    function automatic logic code_allowed(input logic [7:0] c, input logic secured,
                                          input logic special);
        if (!secured) begin
            code_allowed = 1'b1;
        end else begin
            code_allowed = (c == nvmsec_pkg::CMD_EV_ALL) || (c == nvmsec_pkg::CMD_UNSECURE) ||
                           (c == nvmsec_pkg::CMD_KEY_VER) ||
                           (special && (c == nvmsec_pkg::CMD_ERS_ALL));
        end
    endfunction

    // ********************************
    // shared combinational terms
    // ********************************
    logic       bus_req;
    logic       bus_wr;
    logic       launch;
    logic       held;
    logic       secured;
    logic       key_match;
    logic       key_bad;
    logic [7:0] lc;

    assign bus_req   = wb_cyc_i && wb_stb_i && !st_r.ack;
    assign bus_wr    = bus_req && wb_we_i;
    assign launch    = bus_wr && (wb_adr_i == nvmsec_pkg::OFS_CMD) && wb_sel_i[0];
    assign lc        = wb_dat_i[7:0];
    assign held      = !st_r.rst_s2 || st_r.dbg_rst;
    assign secured   = (st_r.sec[1:0] != nvmsec_pkg::SEC_UNSECURED);
    // a stored word of all zeros or all ones can never match
    assign key_match = (nvm_cfg.keys == st_r.keys_in);
    always_comb begin
        key_bad = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if ((nvm_cfg.keys[16*i +: 16] == nvmsec_pkg::KEY_ALL_ZERO) ||
                (nvm_cfg.keys[16*i +: 16] == nvmsec_pkg::KEY_ALL_ONE)) begin
                key_bad = 1'b1;
            end
        end
    end

    // ********************************
    // next state
    // ********************************
    // one process computes the whole next state; bus, decode and sequencing share it
    always_comb begin
        st_nxt          = st_r;
        st_nxt.ack      = bus_req;
        st_nxt.op.start = 1'b0;
        st_nxt.sec_wr   = 1'b0;
        st_nxt.rst_s1   = sys_reset_n;
        st_nxt.rst_s2   = st_r.rst_s1;
        st_nxt.held_d   = held;
        st_nxt.dat      = 32'h0000_0000;

        // register reads answer in the acknowledge cycle
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                nvmsec_pkg::OFS_CMD:  st_nxt.dat = {23'h000000, st_r.cmd_ee, st_r.cmd_code};
                nvmsec_pkg::OFS_STAT: st_nxt.dat = {27'h0000000, st_r.op_failed, st_r.lockout,
                    st_r.prot_viol, st_r.acc_err, st_r.state != nvmsec_pkg::NVMSEC_IDLE};
                nvmsec_pkg::OFS_KEYA: st_nxt.dat = st_r.keys_in[31:0];
                nvmsec_pkg::OFS_KEYB: st_nxt.dat = st_r.keys_in[63:32];
                nvmsec_pkg::OFS_PROT: st_nxt.dat = {28'h0000000, st_r.eopen, st_r.ldis,
                    st_r.hdis, st_r.fopen};
                nvmsec_pkg::OFS_SEC:  st_nxt.dat = {24'h000000, st_r.sec};
                nvmsec_pkg::OFS_DBG:  st_nxt.dat = {28'h0000000, st_r.dbg_rst, 2'h0,
                    st_r.dbg_erase};
                default:              st_nxt.dat = 32'h0000_0000; // unmapped reads zero
            endcase
        end

        // plain register writes
        if (bus_wr && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                nvmsec_pkg::OFS_STAT: begin
                    if (wb_dat_i[nvmsec_pkg::STAT_ACCESS_ERROR_FLAG_BIT]) st_nxt.acc_err   = 1'b0;
                    if (wb_dat_i[nvmsec_pkg::STAT_PVIOL_BIT])  st_nxt.prot_viol = 1'b0;
                    if (wb_dat_i[nvmsec_pkg::STAT_FAIL_BIT])   st_nxt.op_failed = 1'b0;
                end
                nvmsec_pkg::OFS_PROT: begin
                    st_nxt.fopen = wb_dat_i[nvmsec_pkg::PROT_FOPEN_BIT];
                    st_nxt.hdis  = wb_dat_i[nvmsec_pkg::PROT_HDIS_BIT];
                    st_nxt.ldis  = wb_dat_i[nvmsec_pkg::PROT_LDIS_BIT];
                    st_nxt.eopen = wb_dat_i[nvmsec_pkg::PROT_EOPEN_BIT];
                end
                nvmsec_pkg::OFS_DBG: begin
                    st_nxt.dbg_erase = wb_dat_i[nvmsec_pkg::DBG_ERASE_BIT];
                    st_nxt.dbg_rst   = wb_dat_i[nvmsec_pkg::DBG_RST_BIT];
                end
                default: ;
            endcase
        end
        // key words may only change while no compare is running
        if (bus_wr && st_r.state == nvmsec_pkg::NVMSEC_IDLE) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b] && wb_adr_i == nvmsec_pkg::OFS_KEYA)
                    st_nxt.keys_in[8*b +: 8] = wb_dat_i[8*b +: 8];
                if (wb_sel_i[b] && wb_adr_i == nvmsec_pkg::OFS_KEYB)
                    st_nxt.keys_in[32 + 8*b +: 8] = wb_dat_i[8*b +: 8];
            end
        end

        // device reset: lockout and cpu hold clear on entry, security loads on release unless cpu hold is set
        if (held && !st_r.held_d) begin
            st_nxt.lockout  = 1'b0;
            st_nxt.cpu_hold = 1'b0;
        end
        if ((!held && st_r.held_d && !st_r.cpu_hold) || !st_r.loaded) begin
            st_nxt.sec    = nvm_cfg.sec_byte;
            st_nxt.loaded = 1'b1;
        end

        unique case (st_r.state)
            nvmsec_pkg::NVMSEC_IDLE: begin
                if (held && st_r.dbg_erase) begin
                    // debug mass erase ignores protection and security
                    st_nxt.state   = nvmsec_pkg::NVMSEC_DERS;
                    st_nxt.op      = '{1'b1, nvmsec_pkg::CMD_ERS_ALL, 1'b0};
                end else if (launch && !held) begin
                    st_nxt.cmd_code = lc;
                    st_nxt.cmd_ee   = wb_dat_i[nvmsec_pkg::CMD_EE_BIT];
                    if (!code_valid(lc) || st_r.acc_err || st_r.prot_viol) begin
                        st_nxt.acc_err = 1'b1;
                    end else if (!code_allowed(lc, secured, special_mode)) begin
                        st_nxt.acc_err = 1'b1;
                    end else if (lc == nvmsec_pkg::CMD_KEY_VER) begin
                        if (st_r.lockout ||
                            st_r.sec[7:6] != nvmsec_pkg::KEY_ENABLE_FIELD_ENABLED) begin
                            st_nxt.acc_err = 1'b1;
                        end else begin
                            st_nxt.state      = nvmsec_pkg::NVMSEC_KEY;
                            st_nxt.cnt        = nvmsec_pkg::KEY_CMP_CYCLES;
                            st_nxt.read_block = 1'b1;
                        end
                    end else if (lc == nvmsec_pkg::CMD_PGM_ONCE && nvm_cfg.once_used) begin
                        st_nxt.acc_err = 1'b1;
                    end else if (lc == nvmsec_pkg::CMD_ERS_ALL &&
                                 !(st_r.fopen && st_r.hdis && st_r.ldis && st_r.eopen)) begin
                        st_nxt.prot_viol = 1'b1;
                    end else if (lc == nvmsec_pkg::CMD_ERS_BLK &&
                                 !wb_dat_i[nvmsec_pkg::CMD_EE_BIT] &&
                                 !(st_r.fopen && st_r.hdis && st_r.ldis)) begin
                        st_nxt.prot_viol = 1'b1;
                    end else begin
                        // remaining codes are handed to the array engine as decoded
                        st_nxt.state = nvmsec_pkg::NVMSEC_EXEC;
                        st_nxt.op    = '{1'b1, lc, wb_dat_i[nvmsec_pkg::CMD_EE_BIT]};
                    end
                end
            end
            nvmsec_pkg::NVMSEC_EXEC: begin
                if (op_done) begin
                    st_nxt.state = nvmsec_pkg::NVMSEC_IDLE;
                    if (op_fail) begin
                        st_nxt.op_failed = 1'b1;
                    end else if (st_r.op.code == nvmsec_pkg::CMD_UNSECURE) begin
                        st_nxt.sec[1:0] = nvmsec_pkg::SEC_UNSECURED;
                    end
                end else if (held) begin
                    st_nxt.state = nvmsec_pkg::NVMSEC_IDLE; // reset aborts the command
                end
            end
            nvmsec_pkg::NVMSEC_KEY: begin
                // compare takes a fixed window; the array stays read-blocked meanwhile
                if (st_r.cnt != 4'h0) begin
                    st_nxt.cnt = st_r.cnt - 4'h1;
                end else begin
                    st_nxt.state      = nvmsec_pkg::NVMSEC_IDLE;
                    st_nxt.read_block = 1'b0;
                    if (key_match && !key_bad) begin
                        // only the volatile field moves; stored byte, keys, protection stay
                        st_nxt.sec[1:0] = nvmsec_pkg::SEC_UNSECURED;
                    end else begin
                        st_nxt.lockout = 1'b1;
                    end
                end
            end
            nvmsec_pkg::NVMSEC_DERS: begin
                if (op_done) begin
                    st_nxt.state     = nvmsec_pkg::NVMSEC_DPROG;
                    st_nxt.dbg_erase = 1'b0;
                    st_nxt.cpu_hold  = 1'b1;
                    st_nxt.sec[1:0]  = nvmsec_pkg::SEC_UNSECURED;
                    st_nxt.sec_wr    = 1'b1;
                end
            end
            nvmsec_pkg::NVMSEC_DPROG: begin
                // security byte program goes out as one pulse, then back to idle
                if (op_done) st_nxt.state = nvmsec_pkg::NVMSEC_IDLE;
            end
            default: st_nxt.state = nvmsec_pkg::NVMSEC_IDLE;
        endcase
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.sec      <= nvmsec_pkg::SEC_RESET_BYTE;
            st_r.rst_s1   <= 1'b0;
            st_r.rst_s2   <= 1'b0;
            st_r.held_d   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops, except sec_byte_val tied to SEC_ERASED_BYTE
    assign wb_ack_o     = st_r.ack;
    assign wb_dat_o     = st_r.dat;
    assign op_req       = st_r.op;
    assign sec_byte_wr  = st_r.sec_wr;
    assign sec_byte_val = nvmsec_pkg::SEC_ERASED_BYTE;
    assign read_block   = st_r.read_block;
    assign cpu_hold     = st_r.cpu_hold;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_key_read_block: assert property (st_r.state == nvmsec_pkg::NVMSEC_KEY |-> st_r.read_block)
        else $error("array reads not blocked during key compare");
    a_lockout_sticky: assert property (st_r.lockout && !held |=> st_r.lockout)
        else $error("key lockout cleared without reset");
    a_key_refused_lock: assert property (
        st_r.state == nvmsec_pkg::NVMSEC_IDLE && launch && !held && !st_r.dbg_erase &&
        lc == nvmsec_pkg::CMD_KEY_VER && st_r.lockout
        |=> st_r.acc_err && st_r.state == nvmsec_pkg::NVMSEC_IDLE)
        else $error("key command ran while locked out");
    a_key_match_sec: assert property (
        st_r.state == nvmsec_pkg::NVMSEC_KEY && st_r.cnt == 4'h0 && key_match && !key_bad
        |=> st_r.sec[1:0] == nvmsec_pkg::SEC_UNSECURED && !st_r.read_block)
        else $error("matching key did not unsecure");
    a_key_bad_value: assert property (
        st_r.state == nvmsec_pkg::NVMSEC_KEY && st_r.cnt == 4'h0 && key_bad |=> st_r.lockout)
        else $error("forbidden stored key accepted");
    a_bad_code_err: assert property (
        st_r.state == nvmsec_pkg::NVMSEC_IDLE && launch && !held && !code_valid(lc)
        |=> st_r.acc_err && st_r.state == nvmsec_pkg::NVMSEC_IDLE && !st_r.op.start)
        else $error("invalid command code not refused");
    a_erase_all_prot: assert property (
        st_r.op.start && st_r.state == nvmsec_pkg::NVMSEC_EXEC &&
        st_r.op.code == nvmsec_pkg::CMD_ERS_ALL
        |-> st_r.fopen && st_r.hdis && st_r.ldis && st_r.eopen)
        else $error("erase all started under protection");
    a_dbg_erase_done: assert property (
        st_r.state == nvmsec_pkg::NVMSEC_DERS && op_done
        |=> !st_r.dbg_erase && st_r.cpu_hold && st_r.sec_wr ##1 !st_r.sec_wr)
        else $error("debug erase end sequence wrong");
    a_dbg_erase_start: assert property (
        st_r.state == nvmsec_pkg::NVMSEC_IDLE && held && st_r.dbg_erase
        |=> st_r.state == nvmsec_pkg::NVMSEC_DERS && st_r.op.start)
        else $error("debug mass erase not started");
    a_ack_single: assert property (st_r.ack |=> !st_r.ack)
        else $error("ack held longer than one cycle");
    a_secured_gate: assert property (
        st_r.state == nvmsec_pkg::NVMSEC_IDLE && launch && !held && !st_r.dbg_erase &&
        secured && !special_mode && lc == nvmsec_pkg::CMD_PGM
        |=> st_r.acc_err && st_r.state == nvmsec_pkg::NVMSEC_IDLE)
        else $error("command ran while secured");
    a_hold_sticky: assert property (st_r.cpu_hold && !held |=> st_r.cpu_hold)
        else $error("cpu hold dropped without reset");

endmodule // nvmsec_top

// file: sim/nvmsec_engine.sv
// Purpose: array engine model answering each started operation
// Assumes: one done pulse per start or security byte program
// Notes:   never fails; latency set by LAT
module nvmsec_engine #(parameter int LAT = 3) (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // requests and answer
    input  wire nvmsec_pkg::nvmsec_op_t  op_req,
    input  wire logic                    sec_byte_wr,
    output logic                         op_done,
    output logic                         op_fail
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;
    // a new request restarts the count, so overlapping requests give one answer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 4'h0;
            op_done <= 1'b0;
        end else begin
            op_done <= (cnt_r == 4'h1);
            cnt_r   <= (op_req.start || sec_byte_wr) ? LAT[3:0] : cnt_r - 4'(cnt_r != 4'h0);
        end
    end
    assign op_fail = 1'b0;
endmodule // nvmsec_engine

// file: sim/tb.sv
// Purpose: key check, command decode and debug erase scenarios
// Assumes: stored keys 1111 2222 3333 4444, security byte secured with key enable
// Notes:   bus sampled in the active region of each edge
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst_n, cyc, we, pin_n, spm, ack, hold, rblk, swr, done, fail;
    logic [7:0] adr, sval;
    logic [31:0] dat, rd, q;
    nvmsec_pkg::nvmsec_op_t req;
    nvmsec_pkg::nvmsec_cfg_t cfg = {64'h4444_3333_2222_1111, 8'h80, 1'b0};
    int n_errors = 0, checks = 0, n_wr = 0;
    nvmsec_top dut (.ref_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .sys_reset_n(pin_n), .special_mode(spm), .nvm_cfg(cfg), .op_done(done),
        .op_fail(fail), .op_req(req), .sec_byte_wr(swr), .sec_byte_val(sval),
        .read_block(rblk), .cpu_hold(hold));
    nvmsec_engine eng (.ref_clk, .rst_n, .op_req(req), .sec_byte_wr(swr), .op_done(done),
        .op_fail(fail));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // count security byte program pulses
    always @(posedge ref_clk) if (swr === 1'b1) n_wr++;
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one classic cycle; the wait is bounded so a dead slave ends the run
    task automatic rw(logic w, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge ref_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge ref_clk);
        if (i == 20) chk("bus_ack", 1, 0);
        if (i == 20) report_and_stop();
        q = rd;
        cyc <= 1'b0;
    endtask
    task automatic stat(logic [31:0] e, string s);
        rw(0, 8'h04, 0);
        chk(s, e, {27'h0, q[4:0]});
        rw(1, 8'h04, 32'h16);
    endtask
    task automatic s_key();
        rw(1, 8'h00, 32'h06);
        stat(32'h02, "secured_refusal");
        rw(1, 8'h08, 32'h2222_1112);
        rw(1, 8'h0c, 32'h4444_3333);
        rw(1, 8'h00, 32'h0c);
        @(posedge ref_clk);
        chk("read_block", 1, rblk);
        repeat (8) @(posedge ref_clk);
        rw(1, 8'h08, 32'h2222_1111);
        rw(1, 8'h00, 32'h0c);
        stat(32'h0a, "lockout_refusal");
        rw(0, 8'h14, 0);
        chk("still_secured", 0, q[1:0]);
        rw(1, 8'h18, 32'h08);
        rw(1, 8'h18, 32'h00);
        repeat (4) @(posedge ref_clk);
        rw(1, 8'h00, 32'h0c);
        repeat (8) @(posedge ref_clk);
        rw(0, 8'h14, 0);
        chk("unsecured", 2, q[1:0]);
        rw(0, 8'h10, 0);
        chk("prot_kept", 0, q[3:0]);
        chk("byte_writes", 0, n_wr);
    endtask
    task automatic s_decode();
        logic [7:0] c [15] = '{1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 13, 14, 16, 17, 18};
        rw(1, 8'h00, 32'h05);
        stat(32'h02, "invalid_code");
        rw(1, 8'h00, 32'h08);
        stat(32'h04, "erase_all_unprotected");
        rw(1, 8'h10, 32'h0f);
        foreach (c[k]) begin
            rw(1, 8'h00, {23'h0, c[k] > 8'h0f, c[k]});
            repeat (8) @(posedge ref_clk);
            chk("op_code", c[k], req.code);
        end
    endtask
    task automatic s_debug();
        int i;
        // a stored word of all ones must lock out even when presented exactly
        cfg.keys[15:0] <= 16'hffff;
        rw(1, 8'h08, 32'h2222_ffff);
        rw(1, 8'h00, 32'h0c);
        repeat (8) @(posedge ref_clk);
        stat(32'h08, "forbidden_key");
        cfg.keys[15:0] <= 16'h1111;
        pin_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rw(1, 8'h18, 32'h01);
        pin_n <= 1'b1;
        // poll at least once: q still holds the write's empty read data here
        i = 0;
        do begin
            rw(0, 8'h18, 0);
            i++;
        end while (q[0] !== 1'b0 && i < 40);
        chk("erase_bit", 0, q[0]);
        if (q[0] !== 1'b0) report_and_stop();
        chk("cpu_hold", 1, hold);
        chk("byte_value", 32'hfe, sval);
        chk("byte_writes", 1, n_wr);
        rw(0, 8'h14, 0);
        chk("unsecured", 2, q[1:0]);
        pin_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        pin_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("hold_released", 0, hold);
        rw(0, 8'h14, 0);
        chk("reloaded", 0, q[1:0]);
    endtask
    task automatic s_mode();
        rw(1, 8'h00, 32'h08);
        stat(32'h02, "secured_erase_all");
        spm <= 1'b1;
        rw(1, 8'h00, 32'h08);
        repeat (8) @(posedge ref_clk);
        stat(32'h00, "special_erase_all");
    endtask
    initial begin
        {rst_n, cyc, we, adr, dat, pin_n, spm} = {43'h0, 1'b1, 1'b0};
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        s_key();
        s_decode();
        s_debug();
        s_mode();
        report_and_stop();
    end
endmodule // tb
